// File: pkg/plx_pkg.sv
// package for the link-setup and crossover control block
// assumes one 125 MHz clock and a synchronous active-high reset
package plx_pkg;
  localparam int CLK_MHZ         = 125;
  // resolution settle time in microseconds, cycles derived from the clock
  localparam int SETTLE_US       = 2;
  localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
  // parallel-detect wait for partner code words, microseconds
  localparam int PDET_US         = 50;
  localparam int PDET_CYC        = PDET_US * CLK_MHZ;
  localparam int JUMBO_BYTES     = 16384;

  localparam logic [15:0] PAGE_SEL_VAL   = 16'h2a30;
  localparam logic [15:0] PAGE_STD_VAL   = 16'h0000;
  localparam logic [15:0] XOVR_MASK      = 16'h0018;
  localparam logic [15:0] XOVR_FORCE_STR = 16'h0010;
  localparam logic [15:0] XOVR_FORCE_X   = 16'h0018;
  localparam logic [4:0]  REG_PAGE       = 5'h1f;
  localparam logic [4:0]  REG_XOVR       = 5'h05;
  localparam logic [1:0]  IMP_DEFAULT    = 2'h0;

  typedef enum logic [1:0] {
    PLX_SPD_10, PLX_SPD_100, PLX_SPD_1000, PLX_SPD_RSV
  } plx_speed_t;

  // abilities: {1000 full, 1000 half, 100 full, 100 half, 10 full, 10 half}
  typedef logic [5:0] plx_abil_t;

  typedef struct packed {
    logic       an_enable;
    logic       speed_lsb;
    logic       speed_msb;
    logic       full_duplex;
    logic       auto_xovr_en;
    logic       pol_corr_en;
    logic       mdix_pref;
    logic       xovr_forced_an_off;
    logic [1:0] imp_sel;
  } plx_cfg_t;

  typedef struct packed {
    logic       link_up;
    plx_speed_t speed;
    logic       full_duplex;
    logic       master;
    logic       crossed;
    logic       cd_swap;
    logic [3:0] pol_inv;
    logic       par_detect;
  } plx_stat_t;

  typedef struct packed {
    logic        we;
    logic [4:0]  addr;
    logic [15:0] data;
    logic [15:0] mask;
  } plx_mwr_t;
endpackage

// File: src/plx_link_ctrl.sv
// link setup: negotiation, forced modes, parallel detect, crossover control
// assumes management writes and media hints arrive as pins from outside
`timescale 1ns/10ps
//
// Behaviour
// (RULE_01) negotiation runs only while the enable bit is set
// (RULE_02) with negotiation off, speed and duplex come from control bits only
// (RULE_03) a non-negotiating partner is speed-matched by parallel detection
// (RULE_04) best common speed, duplex and gigabit master role are resolved
// (RULE_05) optional next pages are exchanged for the attached MAC
// (RULE_06) management forces straight wiring by paged masked write of 0x0010
// (RULE_07) management forces crossed wiring by paged masked write of 0x0018
// (RULE_08) clearing both masked bits returns crossover to control-bit selection
// (RULE_09) auto crossover handles four pair mappings at all speeds
// (RULE_10) each pair's polarity inversion is detected and corrected alone
// (RULE_11) auto crossover and polarity correction default on after reset
// (RULE_12) resolved crossover and polarity appear as status bits
// (RULE_13) with flag clear, auto crossover continues in forced 10/100
// (RULE_14) receive output impedance default target, alternatives selectable
// (RULE_15) MAC side carries 10, 100 and 1000 Mbps
// (RULE_16) jumbo frames up to 16 kB pass at every speed
// (RULE_17) management restores the page register to zero after paged access
module plx_link_ctrl
  import plx_pkg::*;
#(
  parameter int PDET = PDET_CYC
) (
  input  wire logic       CLOCK,
  input  wire logic       SRST,
  input  wire plx_cfg_t   CFG,
  input  wire plx_abil_t  LOCAL_ABIL,
  input  wire plx_mwr_t   MGMT_WR,
  input  wire logic       PARTNER_PAGE_VLD,
  input  wire plx_abil_t  PARTNER_ABIL,
  input  wire logic [15:0] PARTNER_SEED,
  input  wire logic [15:0] LOCAL_SEED,
  input  wire logic       PARTNER_NP_VLD,
  input  wire logic [15:0] PARTNER_NP,
  input  wire logic       LOCAL_NP_VLD,
  input  wire logic [15:0] LOCAL_NP,
  input  wire logic       MEDIA_SIG_10,
  input  wire logic       MEDIA_SIG_100,
  input  wire logic [3:0] MEDIA_RX_PAIR,
  input  wire logic [3:0] MEDIA_PAIR_INV,
  output plx_stat_t       STATUS,
  output logic            AN_ACTIVE,
  output logic [15:0]     NP_TO_MAC,
  output logic            NP_TO_MAC_VLD,
  output logic [15:0]     NP_TO_MEDIA,
  output logic            NP_TO_MEDIA_VLD,
  output logic [1:0]      RX_IMP_SEL,
  output plx_speed_t      MAC_SPEED,
  output logic [14:0]     JUMBO_LIMIT
);
  logic [1:0]  sig10_s, sig100_s;
  logic [3:0]  rxp_s0, rxp_s1, inv_s0, inv_s1;
  logic        in_page_q;
  logic [1:0]  force_q;
  logic        crossed, cd_swap;
  logic [3:0]  pol_inv;
  logic [$clog2(PDET+1)-1:0] pdet_q;
  plx_abil_t   common;
  logic        auto_xovr;

  function automatic plx_speed_t forced_speed(input logic msb, input logic lsb);
    forced_speed = msb ? (lsb ? PLX_SPD_RSV : PLX_SPD_1000) : (lsb ? PLX_SPD_100 : PLX_SPD_10);
  endfunction

  // media pins from outside the clock domain pass two flops
  always_ff @(posedge CLOCK) begin
    sig10_s  <= {sig10_s[0], MEDIA_SIG_10};
    sig100_s <= {sig100_s[0], MEDIA_SIG_100};
    rxp_s0   <= MEDIA_RX_PAIR;
    rxp_s1   <= rxp_s0;
    inv_s0   <= MEDIA_PAIR_INV;
    inv_s1   <= inv_s0;
  end

  // paged crossover override, page must be selected first
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      in_page_q <= 1'b0;
      force_q   <= 2'h0;
    end else if (MGMT_WR.we) begin
      if (MGMT_WR.addr == REG_PAGE)
        in_page_q <= (MGMT_WR.data == PAGE_SEL_VAL);                   // RULE_17
      else if (in_page_q && MGMT_WR.addr == REG_XOVR && MGMT_WR.mask == XOVR_MASK)
        force_q <= MGMT_WR.data[4:3];                                  // RULE_06 RULE_07 RULE_08
    end
  end

  assign common    = LOCAL_ABIL & PARTNER_ABIL;
  assign auto_xovr = CFG.auto_xovr_en && (CFG.an_enable || !CFG.xovr_forced_an_off); // RULE_11 RULE_13

  plx_xovr #(
    .SETTLE(SETTLE_CYC)
  ) i_plx_xovr (
    .clk        (CLOCK),
    .srst       (SRST),
    .auto_en    (auto_xovr),
    .pol_en     (CFG.pol_corr_en),                                     // RULE_11
    .force_mode (force_q),
    .mdix_pref  (CFG.mdix_pref),
    .rx_on_pair (rxp_s1),
    .pair_inv   (inv_s1),
    .crossed_q  (crossed),
    .cd_swap_q  (cd_swap),
    .pol_inv_q  (pol_inv)
  );

  // speed, duplex and role resolution
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      STATUS    <= '0;
      AN_ACTIVE <= 1'b0;
      pdet_q    <= '0;
    end else begin
      STATUS.crossed <= crossed;                                       // RULE_12
      STATUS.cd_swap <= cd_swap;                                       // RULE_12
      STATUS.pol_inv <= pol_inv;                                       // RULE_12
      AN_ACTIVE      <= CFG.an_enable;                                 // RULE_01
      if (!CFG.an_enable) begin
        pdet_q             <= '0;
        STATUS.link_up     <= 1'b1;
        STATUS.par_detect  <= 1'b0;
        STATUS.speed       <= forced_speed(CFG.speed_msb, CFG.speed_lsb); // RULE_02
        STATUS.full_duplex <= CFG.full_duplex;                         // RULE_02
        STATUS.master      <= 1'b0;
      end else if (PARTNER_PAGE_VLD) begin
        pdet_q            <= '0;
        STATUS.link_up    <= |common;
        STATUS.par_detect <= 1'b0;
        STATUS.master     <= LOCAL_SEED > PARTNER_SEED;                // RULE_04
        unique casez (common)                                          // RULE_04
          6'b1?????: begin STATUS.speed <= PLX_SPD_1000; STATUS.full_duplex <= 1'b1; end
          6'b01????: begin STATUS.speed <= PLX_SPD_1000; STATUS.full_duplex <= 1'b0; end
          6'b001???: begin STATUS.speed <= PLX_SPD_100;  STATUS.full_duplex <= 1'b1; end
          6'b0001??: begin STATUS.speed <= PLX_SPD_100;  STATUS.full_duplex <= 1'b0; end
          6'b00001?: begin STATUS.speed <= PLX_SPD_10;   STATUS.full_duplex <= 1'b1; end
          default:   begin STATUS.speed <= PLX_SPD_10;   STATUS.full_duplex <= 1'b0; end
        endcase
      end else if (sig100_s[1] || sig10_s[1]) begin
        if (pdet_q == PDET[$bits(pdet_q)-1:0]) begin
          STATUS.link_up     <= 1'b1;
          STATUS.par_detect  <= 1'b1;                                  // RULE_03
          STATUS.speed       <= sig100_s[1] ? PLX_SPD_100 : PLX_SPD_10; // RULE_03
          STATUS.full_duplex <= 1'b0;
          STATUS.master      <= 1'b0;
        end else begin
          pdet_q <= pdet_q + 1'b1;
        end
      end else begin
        pdet_q         <= '0;
        STATUS.link_up <= STATUS.link_up && !STATUS.par_detect;
      end
    end
  end

  // next-page relay between MAC and partner
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      NP_TO_MAC       <= '0;
      NP_TO_MAC_VLD   <= 1'b0;
      NP_TO_MEDIA     <= '0;
      NP_TO_MEDIA_VLD <= 1'b0;
    end else begin
      NP_TO_MAC_VLD   <= CFG.an_enable && PARTNER_NP_VLD;              // RULE_05
      NP_TO_MEDIA_VLD <= CFG.an_enable && LOCAL_NP_VLD;                // RULE_05
      if (PARTNER_NP_VLD) NP_TO_MAC <= PARTNER_NP;
      if (LOCAL_NP_VLD) NP_TO_MEDIA <= LOCAL_NP;
    end
  end

  // MAC-side speed, impedance target and frame limit
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RX_IMP_SEL  <= IMP_DEFAULT;                                      // RULE_14
      MAC_SPEED   <= PLX_SPD_10;
      JUMBO_LIMIT <= '0;
    end else begin
      RX_IMP_SEL  <= CFG.imp_sel;                                      // RULE_14
      MAC_SPEED   <= STATUS.speed;                                     // RULE_15
      JUMBO_LIMIT <= 15'(JUMBO_BYTES - 1);                             // RULE_16
    end
  end
endmodule // plx_link_ctrl

// File: src/plx_xovr.sv
// pair mapping and polarity detection for the four media pairs
// assumes pair activity and inversion hints already synchronised
`timescale 1ns/10ps
module plx_xovr
  import plx_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       auto_en,
  input  wire logic       pol_en,
  input  wire logic [1:0] force_mode,
  input  wire logic       mdix_pref,
  input  wire logic [3:0] rx_on_pair,
  input  wire logic [3:0] pair_inv,
  output logic            crossed_q,
  output logic            cd_swap_q,
  output logic [3:0]      pol_inv_q
);
  logic [$clog2(SETTLE+1)-1:0] cnt_q;

  // hunt alternates mappings until receive energy arrives on the expected pair
  always_ff @(posedge clk) begin
    if (srst) begin
      crossed_q <= 1'b0;
      cd_swap_q <= 1'b0;
      cnt_q     <= '0;
    end else if (force_mode == XOVR_FORCE_STR[4:3]) begin
      crossed_q <= 1'b0;
    end else if (force_mode == XOVR_FORCE_X[4:3]) begin
      crossed_q <= 1'b1;
    end else if (!auto_en) begin
      crossed_q <= mdix_pref;
    end else if (rx_on_pair[crossed_q ? 0 : 1]) begin                  // RULE_09
      cnt_q     <= '0;
      cd_swap_q <= rx_on_pair[3] != rx_on_pair[2] && rx_on_pair[crossed_q ? 2 : 3]; // RULE_09
    end else if (cnt_q == SETTLE[$bits(cnt_q)-1:0]) begin
      cnt_q     <= '0;
      crossed_q <= !crossed_q;                                         // RULE_09
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // per-pair inversion, each pair independent
  always_ff @(posedge clk) begin
    if (srst) pol_inv_q <= '0;
    else pol_inv_q <= pol_en ? pair_inv : '0;                          // RULE_10
  end
endmodule // plx_xovr

// File: verification/plx_link_ctrl_properties.sv
// port assertions for the link-setup block
// bound into plx_link_ctrl; one clock, sync reset
`timescale 1ns/10ps
module plx_link_ctrl_chk
  import plx_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire plx_cfg_t    CFG,
  input wire logic        PARTNER_NP_VLD,
  input wire logic [15:0] PARTNER_NP,
  input wire logic        LOCAL_NP_VLD,
  input wire logic [15:0] LOCAL_NP,
  input wire plx_stat_t   STATUS,
  input wire logic        AN_ACTIVE,
  input wire logic [15:0] NP_TO_MAC,
  input wire logic        NP_TO_MAC_VLD,
  input wire logic [15:0] NP_TO_MEDIA,
  input wire logic        NP_TO_MEDIA_VLD,
  input wire logic [1:0]  RX_IMP_SEL,
  input wire plx_speed_t  MAC_SPEED,
  input wire logic [14:0] JUMBO_LIMIT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  rst_clear_a: assert property ($fell(SRST) |-> STATUS == '0 && !AN_ACTIVE && RX_IMP_SEL == IMP_DEFAULT)
    else $error("outputs not cleared by reset");
  an_off_idle_a: assert property (!CFG.an_enable && $past(!CFG.an_enable) |-> !AN_ACTIVE)
    else $error("negotiation active while disabled");
  forced_mode_a: assert property (!CFG.an_enable ##1 !CFG.an_enable && $stable(CFG) ##1 !CFG.an_enable && $stable(CFG) |->
    MAC_SPEED == {CFG.speed_msb, CFG.speed_lsb} && STATUS.full_duplex == CFG.full_duplex)
    else $error("forced speed or duplex wrong");
  np_to_mac_a: assert property (CFG.an_enable && PARTNER_NP_VLD |=> NP_TO_MAC_VLD && NP_TO_MAC == $past(PARTNER_NP))
    else $error("partner next page not passed");
  np_to_media_a: assert property (CFG.an_enable && LOCAL_NP_VLD |=> NP_TO_MEDIA_VLD && NP_TO_MEDIA == $past(LOCAL_NP))
    else $error("local next page not passed");
  imp_follow_a: assert property (1'b1 |=> RX_IMP_SEL == $past(CFG.imp_sel))
    else $error("impedance select not applied");
  jumbo_limit_a: assert property (!$past(SRST) |-> JUMBO_LIMIT == 15'h3fff)
    else $error("jumbo limit wrong");
  speed_code_a: assert property (MAC_SPEED != PLX_SPD_RSV && STATUS.speed != PLX_SPD_RSV)
    else $error("reserved speed code seen");
endmodule // plx_link_ctrl_chk
bind plx_link_ctrl plx_link_ctrl_chk i_plx_link_ctrl_chk (.CLOCK, .SRST, .CFG, .PARTNER_NP_VLD, .PARTNER_NP,
  .LOCAL_NP_VLD, .LOCAL_NP, .STATUS, .AN_ACTIVE, .NP_TO_MAC, .NP_TO_MAC_VLD, .NP_TO_MEDIA, .NP_TO_MEDIA_VLD,
  .RX_IMP_SEL, .MAC_SPEED, .JUMBO_LIMIT);

// File: verification/plx_link_ctrl_test.sv
// self-checking bench for the link-setup block
// partner model drives the far side; checker is bound in
`timescale 1ns/10ps
module plx_link_ctrl_test;
  import plx_pkg::*;
  logic        clk, srst, pnp_vld, lnp_vld, pvld, an_act, mac_vld, med_vld, sig100;
  logic [1:0]  mode, imp;
  logic [3:0]  pinv, rxp;
  logic [15:0] lseed, np_mac, np_med;
  logic [14:0] jumbo;
  plx_abil_t   labil, pabil;
  plx_cfg_t    cfg;
  plx_mwr_t    mwr;
  plx_stat_t   st;
  plx_speed_t  spd;
  int          fail_count;
  int          check_count;
  plx_link_ctrl #(.PDET(8)) i_plx_link_ctrl (
    .CLOCK(clk), .SRST(srst), .CFG(cfg), .LOCAL_ABIL(labil), .MGMT_WR(mwr), .PARTNER_PAGE_VLD(pvld),
    .PARTNER_ABIL(pabil), .PARTNER_SEED(16'h0001), .LOCAL_SEED(lseed), .PARTNER_NP_VLD(pnp_vld),
    .PARTNER_NP(16'ha5c3), .LOCAL_NP_VLD(lnp_vld), .LOCAL_NP(16'h3c5a), .MEDIA_SIG_10(1'b0),
    .MEDIA_SIG_100(sig100), .MEDIA_RX_PAIR(rxp), .MEDIA_PAIR_INV(pinv), .STATUS(st), .AN_ACTIVE(an_act),
    .NP_TO_MAC(np_mac), .NP_TO_MAC_VLD(mac_vld), .NP_TO_MEDIA(np_med), .NP_TO_MEDIA_VLD(med_vld),
    .RX_IMP_SEL(imp), .MAC_SPEED(spd), .JUMBO_LIMIT(jumbo));
  plx_partner i_plx_partner (.clk(clk), .mode(mode), .page_vld(pvld), .abil(pabil), .sig_100(sig100),
    .pair_inv(pinv));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d, logic [15:0] m);
    @(negedge clk);
    mwr = '{1'b1, a, d, m};
    @(negedge clk);
    mwr.we = 1'b0;
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // drop negotiation and partner, then enable again
  task automatic an_restart();
    cfg.an_enable = 1'b0;
    {cfg.speed_msb, cfg.speed_lsb, cfg.full_duplex} = 3'h0;
    mode = 2'h0;
    repeat (4) @(negedge clk);
    cfg.an_enable = 1'b1;
  endtask
  task automatic t_forced();
    cfg.an_enable = 1'b0;
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 2; d++) begin
        {cfg.speed_msb, cfg.speed_lsb} = 2'(s);
        cfg.full_duplex = d[0];
        repeat (3) @(negedge clk);
        chk("speed", 16'(spd), 16'(s));
        chk("duplex", 16'(st.full_duplex), 16'(d));
        chk("an_active", 16'(an_act), 16'h0000);
      end
    end
  endtask
  task automatic t_pardet();
    an_restart();
    mode = 2'h2;
    for (int i = 0; i < 40 && st.par_detect !== 1'b1; i++) @(negedge clk);
    chk("par_detect", 16'(st.par_detect), 16'h0001);
    chk("pd speed", 16'(st.speed), 16'(PLX_SPD_100));
    chk("pd duplex", 16'(st.full_duplex), 16'h0000);
  endtask
  task automatic t_aneg();
    an_restart();
    repeat (2) @(negedge clk);
    chk("an_active", 16'(an_act), 16'h0001);
    mode = 2'h1;
    for (int i = 0; i < 50 && pvld !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    chk("an speed", 16'(st.speed), 16'(PLX_SPD_1000));
    chk("an duplex", 16'(st.full_duplex), 16'h0001);
    chk("master", 16'(st.master), 16'h0001);
    pnp_vld = 1'b1;
    lnp_vld = 1'b1;
    @(negedge clk);
    pnp_vld = 1'b0;
    lnp_vld = 1'b0;
    chk("np mac vld", 16'(mac_vld), 16'h0001);
    chk("np mac", np_mac, 16'ha5c3);
    chk("np media vld", 16'(med_vld), 16'h0001);
    chk("np media", np_med, 16'h3c5a);
  endtask
  task automatic t_xovr();
    logic [15:0] dv [3];
    dv = '{XOVR_FORCE_X, XOVR_FORCE_STR, 16'h0000};
    cfg.auto_xovr_en = 1'b0;
    cfg.mdix_pref = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(REG_PAGE, PAGE_SEL_VAL, 16'hffff);
      wr(REG_XOVR, dv[i], XOVR_MASK);
      wr(REG_PAGE, PAGE_STD_VAL, 16'hffff);
      chk("crossed", 16'(st.crossed), 16'(i != 1));
    end
    wr(REG_XOVR, XOVR_FORCE_STR, XOVR_MASK);
    repeat (3) @(negedge clk);
    chk("crossed unpaged", 16'(st.crossed), 16'h0001);
    cfg.auto_xovr_en = 1'b1;
  endtask
  // energy moves between pairs; the mapping hunt must follow it
  task automatic t_hunt();
    rxp = 4'h2;
    for (int i = 0; i < 600 && st.crossed !== 1'b0; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("hunt straight", 16'(st.crossed), 16'h0000);
    chk("cd straight", 16'(st.cd_swap), 16'h0000);
    cfg.an_enable = 1'b0;
    rxp = 4'h5;
    for (int i = 0; i < 600 && st.crossed !== 1'b1; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("hunt crossed an off", 16'(st.crossed), 16'h0001);
    chk("cd swap", 16'(st.cd_swap), 16'h0001);
    cfg.xovr_forced_an_off = 1'b1;
    cfg.mdix_pref = 1'b0;
    repeat (4) @(negedge clk);
    chk("hunt stopped", 16'(st.crossed), 16'h0000);
    cfg.xovr_forced_an_off = 1'b0;
    cfg.an_enable = 1'b1;
  endtask
  task automatic t_pol();
    mode = 2'h3;
    for (int i = 0; i < 400 && st.pol_inv !== 4'h5; i++) @(negedge clk);
    chk("pol_inv", 16'(st.pol_inv), 16'h0005);
    cfg.pol_corr_en = 1'b0;
    repeat (4) @(negedge clk);
    chk("pol off", 16'(st.pol_inv), 16'h0000);
    cfg.pol_corr_en = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #40000;
    fail_count++;
    end_of_test();
  end
  initial begin
    {srst, pnp_vld, lnp_vld, mode, labil, lseed, mwr, rxp} = '0;
    srst = 1'b1;
    rxp = 4'hf;
    labil = 6'h3f;
    lseed = 16'h8000;
    cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, IMP_DEFAULT};
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk("imp", 16'(imp), 16'(IMP_DEFAULT));
    chk("jumbo", 16'(jumbo), 16'h3fff);
    cfg.imp_sel = 2'h2;
    repeat (2) @(negedge clk);
    chk("imp alt", 16'(imp), 16'h0002);
    t_forced();
    t_pardet();
    t_aneg();
    t_xovr();
    t_hunt();
    t_pol();
    end_of_test();
  end
endmodule // plx_link_ctrl_test

// File: verification/plx_partner.sv
// far-side link partner: base page, forced signalling, pair polarity
// mode comes from the bench; outputs change on the falling edge
`timescale 1ns/10ps
module plx_partner
  import plx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  output logic            page_vld,
  output plx_abil_t       abil,
  output logic            sig_100,
  output logic [3:0]      pair_inv
);
  logic [1:0] mode_q;
  logic [1:0] seen_q;
  initial begin
    {page_vld, abil, sig_100, pair_inv, mode_q, seen_q} = '0;
  end
  always @(posedge clk) mode_q <= mode;
  // one page per session; ability lines wander outside it
  always @(negedge clk) begin
    seen_q   <= mode_q;
    page_vld <= mode_q == 2'h1 && seen_q != 2'h1;
    abil     <= mode_q == 2'h1 ? 6'h2c : ~abil;
    sig_100  <= mode_q == 2'h2;
    pair_inv <= mode_q == 2'h3 ? 4'h5 : 4'h0;
  end
endmodule // plx_partner
